// ---- verilog/peak_hold_map.svh ----
// register offsets, reset values and channel count for the peak-hold bank
`ifndef PEAK_HOLD_MAP_SVH
`define PEAK_HOLD_MAP_SVH
`define PH_CHANNELS        8
`define PH_HIGHEST_BASE    8'h60
`define PH_HIGHEST_CH0_LO  8'h60
`define PH_HIGHEST_CH0_HI  8'h61
`define PH_HIGHEST_CH1_LO  8'h62
`define PH_HIGHEST_CH1_HI  8'h63
`define PH_HIGHEST_CH2_LO  8'h64
`define PH_HIGHEST_CH2_HI  8'h65
`define PH_HIGHEST_CH3_LO  8'h66
`define PH_HIGHEST_CH3_HI  8'h67
`define PH_HIGHEST_CH4_LO  8'h68
`define PH_HIGHEST_CH4_HI  8'h69
`define PH_HIGHEST_CH5_LO  8'h6a
`define PH_HIGHEST_CH5_HI  8'h6b
`define PH_HIGHEST_CH6_LO  8'h6c
`define PH_HIGHEST_CH6_HI  8'h6d
`define PH_HIGHEST_CH7_LO  8'h6e
`define PH_HIGHEST_CH7_HI  8'h6f
`define PH_LOWEST_BASE     8'h80
`define PH_LOWEST_CH0_LO   8'h80
`define PH_LOWEST_CH0_HI   8'h81
`define PH_LOWEST_CH1_LO   8'h82
`define PH_LOWEST_CH1_HI   8'h83
`define PH_LOWEST_CH2_LO   8'h84
`define PH_LOWEST_CH2_HI   8'h85
`define PH_LOWEST_CH3_LO   8'h86
`define PH_LOWEST_CH3_HI   8'h87
`define PH_LOWEST_CH4_LO   8'h88
`define PH_LOWEST_CH4_HI   8'h89
`define PH_LOWEST_CH5_LO   8'h8a
`define PH_LOWEST_CH5_HI   8'h8b
`define PH_LOWEST_CH6_LO   8'h8c
`define PH_LOWEST_CH6_HI   8'h8d
`define PH_LOWEST_CH7_LO   8'h8e
`define PH_LOWEST_CH7_HI   8'h8f
`define PH_LOWEST_LAST     8'h8f
`define PH_HIGHEST_RESET   16'h0000
`define PH_LOWEST_RESET    16'hffff
`define PH_BYTE_HIGHEST_RST 8'h00
`define PH_BYTE_LOWEST_RST  8'hff
`define PH_UNMAPPED_DATA   8'h00
`endif

// ---- verilog/peak_hold_pkg.sv ----
// types shared by the peak-hold bank
`default_nettype none
package peak_hold_pkg;
	typedef logic [15:0] code_t;
	typedef logic [7:0]  byte_t;
	typedef logic [2:0]  chan_t;
	typedef enum logic {
		kind_highest,
		kind_lowest
	} extreme_kind_t;
endpackage
`default_nettype wire

// ---- verilog/peak_track_if.sv ----
// carrier between the bank and one channel tracker
`timescale 1ns/1ps
`default_nettype none
interface peak_track_if;
	logic                  sample_valid;
	peak_hold_pkg::code_t  sample_code;
	logic                  restart_lo;
	logic                  restart_hi;
	peak_hold_pkg::code_t  stored;
	modport bank (output sample_valid, output sample_code, output restart_lo,
		output restart_hi, input stored);
	modport tracker (input sample_valid, input sample_code, input restart_lo,
		input restart_hi, output stored);
endinterface
`default_nettype wire

// ---- verilog/peak_tracker.sv ----
// one channel's highest or lowest code holder
`timescale 1ns/1ps
`default_nettype none
`include "peak_hold_map.svh"
module peak_tracker #(
	parameter peak_hold_pkg::extreme_kind_t KIND = peak_hold_pkg::kind_highest
) (
	input  wire logic           i_core_clk,
	input  wire logic           i_rst_b,
	peak_track_if.tracker       trk
);
	peak_hold_pkg::code_t value_q;
	peak_hold_pkg::code_t value_d;
	peak_hold_pkg::code_t rst_val;
	wire                  beats;
	assign rst_val = (KIND == peak_hold_pkg::kind_highest) ? `PH_HIGHEST_RESET
		: `PH_LOWEST_RESET;
	// both bytes compared as one code
	assign beats = (KIND == peak_hold_pkg::kind_highest) ?
		(trk.sample_code > value_q) : (trk.sample_code < value_q);
	always_comb begin
		value_d = value_q;
		// a read restarts the byte; a same-cycle sample then wins only if it beats the partly restarted value_d
		if (trk.restart_lo) begin
			value_d[7:0] = rst_val[7:0];
		end
		if (trk.restart_hi) begin
			value_d[15:8] = rst_val[15:8];
		end
		if (trk.sample_valid && (beats || trk.restart_lo || trk.restart_hi)) begin
			if (trk.restart_lo || trk.restart_hi) begin
				if (KIND == peak_hold_pkg::kind_highest ?
					(trk.sample_code > value_d) : (trk.sample_code < value_d)) begin
					value_d = trk.sample_code;
				end
			end else begin
				value_d = trk.sample_code;
			end
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			value_q <= rst_val;
		end else begin
			value_q <= value_d;
		end
	end
	assign trk.stored = value_q;
endmodule
`default_nettype wire

// ---- verilog/peak_hold_bank.sv ----
// per-channel highest and lowest conversion code registers, each byte restarted to its reset value on read
`timescale 1ns/1ps
`default_nettype none
`include "peak_hold_map.svh"
module peak_hold_bank (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_conv_valid,
	input  wire logic [2:0]  i_conv_channel,
	input  wire logic [15:0] i_conv_code,
	input  wire logic [7:0]  i_analog_input_mask,
	input  wire logic        i_reg_read,
	input  wire logic [7:0]  i_reg_addr,
	output logic             o_reg_read_valid,
	output logic [7:0]       o_reg_read_data
);
	peak_track_if hi_if [`PH_CHANNELS] ();
	peak_track_if lo_if [`PH_CHANNELS] ();

	wire        hit_highest;
	wire        hit_lowest;
	wire [2:0]  sel_chan;
	wire        sel_upper;
	wire [15:0] hi_codes [`PH_CHANNELS];
	wire [15:0] lo_codes [`PH_CHANNELS];
	wire [15:0] sel_code;
	wire [7:0]  read_byte;
	wire [7:0]  hi_sel_lo;
	wire [7:0]  hi_sel_hi;
	wire [7:0]  lo_sel_lo;
	wire [7:0]  lo_sel_hi;

	// exact byte decode: a stray address must never restart a tracker
	assign hi_sel_lo[0] = (i_reg_addr == `PH_HIGHEST_CH0_LO);
	assign hi_sel_hi[0] = (i_reg_addr == `PH_HIGHEST_CH0_HI);
	assign hi_sel_lo[1] = (i_reg_addr == `PH_HIGHEST_CH1_LO);
	assign hi_sel_hi[1] = (i_reg_addr == `PH_HIGHEST_CH1_HI);
	assign hi_sel_lo[2] = (i_reg_addr == `PH_HIGHEST_CH2_LO);
	assign hi_sel_hi[2] = (i_reg_addr == `PH_HIGHEST_CH2_HI);
	assign hi_sel_lo[3] = (i_reg_addr == `PH_HIGHEST_CH3_LO);
	assign hi_sel_hi[3] = (i_reg_addr == `PH_HIGHEST_CH3_HI);
	assign hi_sel_lo[4] = (i_reg_addr == `PH_HIGHEST_CH4_LO);
	assign hi_sel_hi[4] = (i_reg_addr == `PH_HIGHEST_CH4_HI);
	assign hi_sel_lo[5] = (i_reg_addr == `PH_HIGHEST_CH5_LO);
	assign hi_sel_hi[5] = (i_reg_addr == `PH_HIGHEST_CH5_HI);
	assign hi_sel_lo[6] = (i_reg_addr == `PH_HIGHEST_CH6_LO);
	assign hi_sel_hi[6] = (i_reg_addr == `PH_HIGHEST_CH6_HI);
	assign hi_sel_lo[7] = (i_reg_addr == `PH_HIGHEST_CH7_LO);
	assign hi_sel_hi[7] = (i_reg_addr == `PH_HIGHEST_CH7_HI);

	// lowest pairs climb from the base, channel 0 first
	assign lo_sel_lo[0] = (i_reg_addr == `PH_LOWEST_CH0_LO);
	assign lo_sel_hi[0] = (i_reg_addr == `PH_LOWEST_CH0_HI);
	assign lo_sel_lo[1] = (i_reg_addr == `PH_LOWEST_CH1_LO);
	assign lo_sel_hi[1] = (i_reg_addr == `PH_LOWEST_CH1_HI);
	assign lo_sel_lo[2] = (i_reg_addr == `PH_LOWEST_CH2_LO);
	assign lo_sel_hi[2] = (i_reg_addr == `PH_LOWEST_CH2_HI);
	assign lo_sel_lo[3] = (i_reg_addr == `PH_LOWEST_CH3_LO);
	assign lo_sel_hi[3] = (i_reg_addr == `PH_LOWEST_CH3_HI);
	assign lo_sel_lo[4] = (i_reg_addr == `PH_LOWEST_CH4_LO);
	assign lo_sel_hi[4] = (i_reg_addr == `PH_LOWEST_CH4_HI);
	assign lo_sel_lo[5] = (i_reg_addr == `PH_LOWEST_CH5_LO);
	assign lo_sel_hi[5] = (i_reg_addr == `PH_LOWEST_CH5_HI);
	assign lo_sel_lo[6] = (i_reg_addr == `PH_LOWEST_CH6_LO);
	assign lo_sel_hi[6] = (i_reg_addr == `PH_LOWEST_CH6_HI);
	assign lo_sel_lo[7] = (i_reg_addr == `PH_LOWEST_CH7_LO);
	assign lo_sel_hi[7] = (i_reg_addr == `PH_LOWEST_CH7_HI);

	// each channel owns an even/odd byte pair
	assign hit_highest = (i_reg_addr >= `PH_HIGHEST_BASE) &&
		(i_reg_addr <= `PH_HIGHEST_CH7_HI);
	assign hit_lowest = (i_reg_addr >= `PH_LOWEST_BASE) &&
		(i_reg_addr <= `PH_LOWEST_LAST);
	// channel and byte half straight from the address bits
	assign sel_chan = i_reg_addr[3:1];
	assign sel_upper = i_reg_addr[0];

	// per-channel wiring; the trackers themselves are placed below
	genvar g;
	generate
		for (g = 0; g < `PH_CHANNELS; g++) begin : g_chan
			wire take;
			// only channels set as analog inputs feed the trackers
			assign take = i_conv_valid && (i_conv_channel == 3'(g)) &&
				i_analog_input_mask[g];
			assign hi_if[g].sample_valid = take;
			assign hi_if[g].sample_code = i_conv_code;
			assign hi_if[g].restart_lo = i_reg_read && hi_sel_lo[g];
			assign hi_if[g].restart_hi = i_reg_read && hi_sel_hi[g];
			assign lo_if[g].sample_valid = take;
			assign lo_if[g].sample_code = i_conv_code;
			assign lo_if[g].restart_lo = i_reg_read && lo_sel_lo[g];
			assign lo_if[g].restart_hi = i_reg_read && lo_sel_hi[g];
			assign hi_codes[g] = hi_if[g].stored;
			assign lo_codes[g] = lo_if[g].stored;
		end
	endgenerate

	// highest-code trackers, one per channel
	peak_tracker #(.KIND(peak_hold_pkg::kind_highest)) hi_ch0 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (hi_if[0])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_highest)) hi_ch1 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (hi_if[1])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_highest)) hi_ch2 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (hi_if[2])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_highest)) hi_ch3 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (hi_if[3])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_highest)) hi_ch4 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (hi_if[4])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_highest)) hi_ch5 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (hi_if[5])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_highest)) hi_ch6 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (hi_if[6])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_highest)) hi_ch7 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (hi_if[7])
	);

	// lowest-code trackers, one per channel
	peak_tracker #(.KIND(peak_hold_pkg::kind_lowest)) lo_ch0 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (lo_if[0])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_lowest)) lo_ch1 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (lo_if[1])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_lowest)) lo_ch2 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (lo_if[2])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_lowest)) lo_ch3 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (lo_if[3])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_lowest)) lo_ch4 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (lo_if[4])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_lowest)) lo_ch5 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (lo_if[5])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_lowest)) lo_ch6 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (lo_if[6])
	);

	peak_tracker #(.KIND(peak_hold_pkg::kind_lowest)) lo_ch7 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.trk        (lo_if[7])
	);

	// value is taken before the restart lands, so the read sees the old extreme
	assign sel_code = hit_highest ? hi_codes[sel_chan] : lo_codes[sel_chan];
	assign read_byte = !(hit_highest || hit_lowest) ? `PH_UNMAPPED_DATA :
		(sel_upper ? sel_code[15:8] : sel_code[7:0]);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			o_reg_read_valid <= 1'b0;
			o_reg_read_data  <= 8'h00;
		end else begin
			o_reg_read_valid <= i_reg_read;
			o_reg_read_data  <= i_reg_read ? read_byte : o_reg_read_data;
		end
	end
endmodule
`default_nettype wire

// ---- test/host_reader.sv ----
// host model that issues register reads
`timescale 1ns/1ps
`default_nettype none
module host_reader (
	input  wire logic       i_core_clk,
	input  wire logic       i_go,
	input  wire logic [7:0] i_addr,
	output logic            o_read = 1'b0,
	output logic      [7:0] o_addr = 8'h00
);
	always @(posedge i_core_clk) begin
		o_read <= i_go;
		o_addr <= i_go ? i_addr : ~o_addr; // idle address alternates between the last address and its inverse
	end
endmodule
`default_nettype wire

// ---- test/bank_properties.sv ----
// port assertions for the peak-hold bank
`timescale 1ns/1ps
`default_nettype none
module bank_properties (
	input wire logic       i_core_clk,
	input wire logic       i_rst_b,
	input wire logic       i_conv_valid,
	input wire logic       i_reg_read,
	input wire logic       o_reg_read_valid,
	input wire logic [2:0] i_conv_channel,
	input wire logic [7:0] i_analog_input_mask,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] o_reg_read_data
);
	wire logic hh = i_reg_read && i_reg_addr[7:4] == 4'h6;
	wire logic hl = i_reg_read && i_reg_addr[7:4] == 4'h8;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	property p_ans; i_reg_read |=> o_reg_read_valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_quiet; !i_reg_read |=> !o_reg_read_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("stray answer");
	property p_hold; !i_reg_read |=> $stable(o_reg_read_data); endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_void; i_reg_read && !hh && !hl |=> o_reg_read_data == 8'h00; endproperty
	a_void: assert property (p_void) else $error("unmapped data");
	property p_hclr; hh && !i_conv_valid ##1 hh && $stable(i_reg_addr) |=> o_reg_read_data == 8'h00;
	endproperty
	a_hclr: assert property (p_hclr) else $error("highest kept");
	property p_lset; hl && !i_conv_valid ##1 hl && $stable(i_reg_addr) |=> o_reg_read_data == 8'hff;
	endproperty
	a_lset: assert property (p_lset) else $error("lowest kept");
	property p_mask; hh && !i_analog_input_mask[i_conv_channel] ##1 hh && $stable(i_reg_addr)
		|=> o_reg_read_data == 8'h00; endproperty
	a_mask: assert property (p_mask) else $error("masked sample kept");
	property p_hrst; $rose(i_rst_b) && hh |=> o_reg_read_data == 8'h00; endproperty
	a_hrst: assert property (p_hrst) else $error("highest reset");
	property p_lrst; $rose(i_rst_b) && hl |=> o_reg_read_data == 8'hff; endproperty
	a_lrst: assert property (p_lrst) else $error("lowest reset");
	c_again: cover property (hh ##1 hh && $stable(i_reg_addr));
	c_mask: cover property (i_conv_valid && !i_analog_input_mask[i_conv_channel]);
	c_lrst: cover property ($rose(i_rst_b) && hl);
endmodule
bind peak_hold_bank bank_properties bank_properties_inst (.*);
`default_nettype wire

// ---- test/test_peak_hold_bank.sv ----
// random and corner-case bench for the peak-hold bank
`timescale 1ns/1ps
`default_nettype none
module test_peak_hold_bank;
	logic        clk = 0, rst_b = 0, cv = 0, go = 0, rd, vld, was_rd = 0;
	logic [2:0]  ch = 0;
	logic [7:0]  msk = 0, ga = 0, ad, dat, want;
	logic [15:0] code = 0, hi[8], lo[8];
	logic [31:0] s = 32'h6808;
	int          miscompares = 0, compares = 0;
	host_reader host_reader_inst (.i_core_clk(clk), .i_go(go), .i_addr(ga), .o_read(rd),
		.o_addr(ad));
	peak_hold_bank peak_hold_bank_inst (.i_core_clk(clk), .i_rst_b(rst_b), .i_conv_valid(cv),
		.i_conv_channel(ch), .i_conv_code(code), .i_analog_input_mask(msk), .i_reg_read(rd),
		.i_reg_addr(ad), .o_reg_read_valid(vld), .o_reg_read_data(dat));
	initial forever #20 clk = ~clk;
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	function automatic logic [7:0] pick(logic [15:0] v, logic up);
		return up ? v[15:8] : v[7:0];
	endfunction
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// reads stay queued through reset so one lands on the release edge
	task automatic rst(logic [7:0] a);
		rst_b <= 0;
		go <= 1;
		ga <= a;
		repeat (3) @(posedge clk);
		foreach (hi[i]) {hi[i], lo[i]} = 32'h0000ffff;
		rst_b <= 1;
	endtask
	always @(posedge clk) was_rd <= rst_b && rd;
	always @(posedge clk) if (rst_b) begin
		check({7'h00, vld}, {7'h00, was_rd});
		if (vld) check(dat, want);
		want <= ad[7:4] == 4'h6 ? pick(hi[ad[3:1]], ad[0]) :
			ad[7:4] == 4'h8 ? pick(lo[ad[3:1]], ad[0]) : 8'h00;
		if (rd && ad[7:4] == 4'h6) hi[ad[3:1]] &= ad[0] ? 16'h00ff : 16'hff00;
		if (rd && ad[7:4] == 4'h8) lo[ad[3:1]] |= ad[0] ? 16'hff00 : 16'h00ff;
		if (cv && msk[ch] && code > hi[ch]) hi[ch] = code;
		if (cv && msk[ch] && code < lo[ch]) lo[ch] = code;
	end
	initial begin
		rst(8'h6e);
		for (int n = 0; n < 64; n++) @(posedge clk) ga <= 8'h60 + 8'(n);
		$display("reset sweep done");
		// let the last sweep address go out before reset takes the bus again
		@(posedge clk);
		rst(8'h80);
		repeat (3000) begin
			@(posedge clk) s = xs(s);
			go <= s[0];
			cv <= s[10];
			ch <= s[13:11];
			msk <= s[21:14];
			code <= s[31:16];
			// keeping the address often gives back-to-back reads of one byte
			if (!s[1]) ga <= s[4:2] == 0 ? s[15:8] : {s[5] ? 4'h8 : 4'h6, s[9:6]};
		end
		$display("random run done");
		test_done;
	end
endmodule
`default_nettype wire
